// file: rtl/pdcc_pll_ctrl.sv
// Purpose: Digital control of an integer-N synthesizer
// Assumes: All pins synchronous to clk_in; oscillator and reference arrive as levels
// Notes: Calibration engine itself is analog; this block only times and gates it
// Overview of operation
// - Address 0010 writes counter setup word
// - Bits 24..12 set B, 3 to 8191
// - Bits 11..6 set A, 0 to 63
// - Bits 5..4 pick prescaler 8/9 to 64/65
// - Prescaler clocks A and B counters
// - Lock-load bit transfers dividers, self-clears on lock
// - Bits 28..25 select test output source
// - Fourteen-bit reference divider, 1 to 16383
// - Phase detector compares both dividers, drives pump
// - Address 0000 writes device setup word
// - Setup defaults: positive polarity, reference divider 1, all else zero
// - Setup bits 9..8 choose output division
// - Calibration word holds reference integer and hundredths
// - Calibration bits 30..18 hold target MHz
// - Start bit runs 5ms calibration, refuses calibration and counter writes
// - Reset bit clears stored calibration data
// - 32-bit words, LSB first, serial clock rising
// - Strobe rising edge copies word to register
`timescale 1ns/100ps
`default_nettype none
module pdcc_pll_ctrl #(
   parameter int CAL_CYCLES = pdcc_pkg::CAL_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Serial programming port
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   input wire logic ser_load_in,
   // Chip pins
   input wire logic chip_en_in,
   input wire logic outbuf_en_in,
   // Divider inputs
   input wire logic ref_in,
   input wire logic presc_in,
   // Phase detector and pump
   output logic pump_up_out,
   output logic pump_dn_out,
   output logic pump_oe_out,
   output logic [2:0] pump_current_out,
   output logic [1:0] antibacklash_width_out,
   // Output buffer
   output logic [1:0] out_div_sel_out,
   output logic buffer_on_out,
   // Status and test
   output logic lock_detect_out,
   output logic test_out_out,
   output logic test_oe_out,
   output logic cal_busy_out,
   output logic [12:0] vco_target_mhz_out
);
   pdcc_link_if link();
   logic [31:0] setup;
   logic [31:0] calib;
   logic [31:0] counter;
   logic [13:0] input_divider_value_work;
   logic [13:0] input_divider_value_cnt;
   logic ref_q;
   logic presc_q;
   logic ref_tick;
   logic cal_valid;
   logic first_load;
   logic [31:0] cal_cnt;
   logic [1:0] fb_seen;
   logic [2:0] good_run;
   logic up_q;
   logic dn_q;
   pdcc_pkg::pdcc_state_t state;
   pdcc_pkg::pdcc_state_t next_state;

   ////////////////////////////////////////////////////////////////////////
   // Word decode
   wire [3:0] addr = link.word[3:0];
   wire wr_setup = link.word_stb && addr == pdcc_pkg::ADDR_SETUP;
   wire cal_busy = state == pdcc_pkg::ST_CAL;
   // Calibration and counter words bounce while calibrating
   wire wr_calib = link.word_stb && addr == pdcc_pkg::ADDR_CALIB && !cal_busy;
   wire wr_counter = link.word_stb && addr == pdcc_pkg::ADDR_COUNTER && !cal_busy;
   wire soft_rst = wr_setup && link.word[pdcc_pkg::SU_RESET];
   wire cal_start = wr_calib && link.word[pdcc_pkg::CL_START];
   wire cal_end = cal_busy && cal_cnt == CAL_CYCLES - 1;
   // First word after calibration loads directly, later ones need lock-load
   wire load_work = wr_counter && (first_load || link.word[pdcc_pkg::CN_LOCK_LOAD]);
   wire locked = state == pdcc_pkg::ST_LOCKED;
   wire ref_edge = chip_en_in && ref_in && !ref_q;
   wire presc_edge = chip_en_in && presc_in && !presc_q;
   wire [13:0] input_divider_value_eff = (input_divider_value_work == 14'h0000) ? 14'h0001 : input_divider_value_work;
   wire [3:0] tmux = counter[pdcc_pkg::CN_TMUX_LSB +: 4];

   ////////////////////////////////////////////////////////////////////////
   pdcc_serial_rx u_rx (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .ser_clk_in(ser_clk_in),
      .ser_data_in(ser_data_in),
      .ser_load_in(ser_load_in),
      .link(link)
   );

   pdcc_fb_divider u_fb (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .presc_edge_in(presc_edge),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////////
   // Device setup word; reset bit restores defaults
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         setup <= pdcc_pkg::SETUP_RESET;
      end else if (soft_rst) begin
         setup <= pdcc_pkg::SETUP_RESET;
      end else if (wr_setup) begin
         setup <= link.word;
      end
   end

   // Calibration word; start bit self-clears at the end of the run
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         calib <= 32'h0000_0000;
      end else if (soft_rst) begin
         calib <= 32'h0000_0000;
      end else if (wr_calib) begin
         calib <= link.word;
      end else if (cal_end) begin
         calib[pdcc_pkg::CL_START] <= 1'b0;
      end
   end

   // Counter word; lock-load self-clears once locked
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         counter <= 32'h0000_0000;
      end else if (soft_rst) begin
         counter <= 32'h0000_0000;
      end else if (wr_counter) begin
         counter <= link.word;
      end else if (locked) begin
         counter[pdcc_pkg::CN_LOCK_LOAD] <= 1'b0;
      end
   end

   // Working dividers, held until a load is allowed
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.b_val <= 13'h0003;
         link.a_val <= 6'h00;
         link.psc_sel <= 2'h0;
         input_divider_value_work <= 14'h0001;
      end else if (load_work) begin
         link.b_val <= link.word[pdcc_pkg::CN_B_LSB +: pdcc_pkg::B_W];
         link.a_val <= link.word[pdcc_pkg::CN_A_LSB +: pdcc_pkg::A_W];
         link.psc_sel <= link.word[pdcc_pkg::CN_PSC_LSB +: 2];
         input_divider_value_work <= setup[pdcc_pkg::SU_INPUT_DIVIDER_VALUE_LSB +: pdcc_pkg::R_W];
      end
   end

   // Calibration bookkeeping; stored data dropped by soft reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cal_valid <= 1'b0;
         first_load <= 1'b1;
         cal_cnt <= 32'h0000_0000;
      end else begin
         cal_cnt <= cal_busy ? cal_cnt + 32'h0000_0001 : 32'h0000_0000;
         if (soft_rst) begin
            cal_valid <= 1'b0;
            first_load <= 1'b1;
         end else if (cal_end) begin
            cal_valid <= 1'b1;
            first_load <= 1'b1;
         end else if (load_work) begin
            first_load <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Loop control state
   always_comb begin
      next_state = state;
      case (state)
         pdcc_pkg::ST_IDLE: begin
            if (cal_start) next_state = pdcc_pkg::ST_CAL;
            else if (load_work) next_state = pdcc_pkg::ST_WAIT_LOCK;
         end
         pdcc_pkg::ST_CAL: begin
            if (cal_end) next_state = pdcc_pkg::ST_IDLE;
         end
         pdcc_pkg::ST_WAIT_LOCK: begin
            if (cal_start) next_state = pdcc_pkg::ST_CAL;
            else if (good_run == pdcc_pkg::LOCK_REFS) next_state = pdcc_pkg::ST_LOCKED;
         end
         pdcc_pkg::ST_LOCKED: begin
            if (cal_start) next_state = pdcc_pkg::ST_CAL;
            else if (load_work) next_state = pdcc_pkg::ST_WAIT_LOCK;
         end
         default: next_state = pdcc_pkg::ST_IDLE;
      endcase
      if (soft_rst) next_state = pdcc_pkg::ST_IDLE;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) state <= pdcc_pkg::ST_IDLE;
      else state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference divider and edge history
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ref_q <= 1'b0;
         presc_q <= 1'b0;
         input_divider_value_cnt <= 14'h0000;
         ref_tick <= 1'b0;
      end else begin
         ref_q <= ref_in;
         presc_q <= presc_in;
         ref_tick <= ref_edge && input_divider_value_cnt >= input_divider_value_eff - 14'h0001;
         if (ref_edge) begin
            input_divider_value_cnt <= (input_divider_value_cnt >= input_divider_value_eff - 14'h0001) ? 14'h0000 : input_divider_value_cnt + 14'h0001;
         end
      end
   end

   // Lock check: exactly one feedback tick per reference period
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fb_seen <= 2'h0;
         good_run <= 3'h0;
      end else if (ref_tick) begin
         fb_seen <= link.fb_tick ? 2'h1 : 2'h0;
         if (state != pdcc_pkg::ST_WAIT_LOCK || fb_seen != 2'h1) good_run <= 3'h0;
         else if (good_run != pdcc_pkg::LOCK_REFS) good_run <= good_run + 3'h1;
      end else if (link.fb_tick && fb_seen != 2'h2) begin
         fb_seen <= fb_seen + 2'h1;
      end
   end

   // Phase detector: up on reference, down on feedback, both clear together
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else if ((up_q || ref_tick) && (dn_q || link.fb_tick)) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         up_q <= up_q || ref_tick;
         dn_q <= dn_q || link.fb_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pump drive: polarity swaps directions, test mode fires both together
   wire pol = setup[pdcc_pkg::SU_POL];
   wire ptest = setup[pdcc_pkg::SU_PUMP_TEST];
   assign pump_up_out = ptest ? (up_q | dn_q) : (pol ? up_q : dn_q);
   assign pump_dn_out = ptest ? (up_q | dn_q) : (pol ? dn_q : up_q);
   assign pump_oe_out = !setup[pdcc_pkg::SU_PUMP_HIGHZ];
   assign pump_current_out = setup[pdcc_pkg::SU_ICP_LSB +: 3];
   assign antibacklash_width_out = setup[pdcc_pkg::SU_ANTIBACKLASH_WIDTH_LSB +: 2];
   assign out_div_sel_out = setup[pdcc_pkg::SU_OMODE_LSB +: 2];
   // External pin wins when the buffer source bit is set
   assign buffer_on_out = setup[pdcc_pkg::SU_BUF_SRC] ? outbuf_en_in
                                                      : !setup[pdcc_pkg::SU_BUF_OFF];
   assign lock_detect_out = locked;
   assign cal_busy_out = cal_busy;
   assign vco_target_mhz_out = calib[pdcc_pkg::CL_TGT_LSB +: 13];

   // Test output mux, registered to keep it glitch free
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         test_out_out <= 1'b0;
         test_oe_out <= 1'b0;
      end else begin
         test_oe_out <= tmux != pdcc_pkg::TM_HIGHZ;
         case (tmux)
            pdcc_pkg::TM_DLOCK: test_out_out <= locked;
            pdcc_pkg::TM_NDIV: test_out_out <= link.fb_tick;
            pdcc_pkg::TM_HIGH: test_out_out <= 1'b1;
            pdcc_pkg::TM_INPUT_DIVIDER_VALUE: test_out_out <= ref_tick;
            pdcc_pkg::TM_ALOCK: test_out_out <= locked;
            pdcc_pkg::TM_READBACK: test_out_out <= !cal_valid;
            default: test_out_out <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_counter_route;
      wr_counter && !soft_rst |=> counter == $past(link.word);
   endproperty
   a_counter_route: assert property (p_counter_route) else $error("counter word not stored");

   property p_busy_refuse;
      link.word_stb && cal_busy && addr == pdcc_pkg::ADDR_COUNTER |=> $stable(counter);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("write accepted while calibrating");

   property p_cal_end;
      cal_busy && cal_cnt == CAL_CYCLES - 1 && !soft_rst |=> !cal_busy && !calib[pdcc_pkg::CL_START];
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration did not finish");

   property p_lock_clear;
      locked && !wr_counter && !soft_rst |=> !counter[pdcc_pkg::CN_LOCK_LOAD];
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock-load not cleared on lock");

   property p_work_load;
      load_work |=> link.b_val == $past(link.word[24:12]) && link.a_val == $past(link.word[11:6]);
   endproperty
   a_work_load: assert property (p_work_load) else $error("working dividers not loaded");

   property p_hold_work;
      wr_counter && !first_load && !link.word[pdcc_pkg::CN_LOCK_LOAD] |=> $stable(link.b_val);
   endproperty
   a_hold_work: assert property (p_hold_work) else $error("dividers loaded without lock-load");

   property p_tmux_highz;
      tmux == pdcc_pkg::TM_HIGHZ |=> !test_oe_out;
   endproperty
   a_tmux_highz: assert property (p_tmux_highz) else $error("test pin driven when high-z");

   property p_soft_reset;
      soft_rst |=> setup == pdcc_pkg::SETUP_RESET && !cal_valid && calib == 32'h0000_0000;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state behind");

   property p_pfd_up;
      ref_tick && !link.fb_tick && !dn_q |=> up_q;
   endproperty
   a_pfd_up: assert property (p_pfd_up) else $error("reference edge did not raise up");
endmodule
`default_nettype wire

// file: inc/pdcc_pkg.sv
// Purpose: Shared constants for the synthesizer divider and calibration control
// Assumes: 40 MHz system clock, 32-bit serial programming words
// Notes: Field positions are the LSB of each field inside a programming word
package pdcc_pkg;
   // Word layout and addressing
   localparam int WORD_W = 32;
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_SETUP = 4'h0;
   localparam logic [3:0] ADDR_CALIB = 4'h1;
   localparam logic [3:0] ADDR_COUNTER = 4'h2;
   // Counter setup word fields
   localparam int CN_LOCK_LOAD = 29;
   localparam int CN_TMUX_LSB = 25;
   localparam int CN_B_LSB = 12;
   localparam int CN_A_LSB = 6;
   localparam int CN_PSC_LSB = 4;
   localparam int B_W = 13;
   localparam int A_W = 6;
   localparam int R_W = 14;
   // Device setup word fields
   localparam int SU_FULL_CAL = 31;
   localparam int SU_PUMP_TEST = 30;
   localparam int SU_PUMP_HIGHZ = 29;
   localparam int SU_POL = 28;
   localparam int SU_ANTIBACKLASH_WIDTH_LSB = 26;
   localparam int SU_INPUT_DIVIDER_VALUE_LSB = 12;
   localparam int SU_BUF_OFF = 11;
   localparam int SU_BUF_SRC = 10;
   localparam int SU_OMODE_LSB = 8;
   localparam int SU_ICP_LSB = 5;
   localparam int SU_RESET = 4;
   // Positive polarity, divide-by-one reference, everything else off
   localparam logic [31:0] SETUP_RESET = 32'h1000_1000;
   // Calibration word fields
   localparam int CL_START = 31;
   localparam int CL_TGT_LSB = 18;
   localparam int CL_FRAC_LSB = 11;
   localparam int CL_INT_LSB = 4;
   // Test output selections
   typedef enum logic [3:0] {
      TM_HIGHZ = 4'h0, TM_DLOCK = 4'h1, TM_NDIV = 4'h2, TM_HIGH = 4'h3,
      TM_INPUT_DIVIDER_VALUE = 4'h4, TM_ALOCK = 4'h5, TM_READBACK = 4'h6, TM_GND = 4'h7
   } pdcc_tmux_t;
   // Loop control states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_CAL = 2'b01, ST_WAIT_LOCK = 2'b10, ST_LOCKED = 2'b11
   } pdcc_state_t;
   // Timing
   localparam int CLK_HZ = 40000000;
   localparam int CAL_TIME_MS = 5;
   localparam int CAL_CYCLES = CAL_TIME_MS * (CLK_HZ / 1000);
   localparam logic [2:0] LOCK_REFS = 3'h4;
   // Low modulus of the dual-modulus prescaler: 8, 16, 32 or 64
   function automatic logic [6:0] psc_low_mod(input logic [1:0] sel);
      psc_low_mod = 7'h08 << sel;
   endfunction
endpackage

// file: inc/pdcc_link_if.sv
// Purpose: Internal carrier between serial receiver, core and feedback divider
// Assumes: All signals on clk_in
// Notes: word_stb is a one-cycle pulse, fb_tick likewise
`timescale 1ns/100ps
`default_nettype none
interface pdcc_link_if;
   logic [31:0] word;
   logic word_stb;
   logic [12:0] b_val;
   logic [5:0] a_val;
   logic [1:0] psc_sel;
   logic fb_tick;
   modport rx (output word, output word_stb);
   modport core (input word, input word_stb, output b_val, output a_val,
      output psc_sel, input fb_tick);
   modport fbdiv (input b_val, input a_val, input psc_sel, output fb_tick);
endinterface
`default_nettype wire

// file: rtl/pdcc_serial_rx.sv
// Purpose: Three-wire serial receiver, LSB first into a 32-bit shift register
// Assumes: Serial pins already synchronous to clk_in
// Notes: Word is presented on the rising edge of the load strobe
`timescale 1ns/100ps
`default_nettype none
module pdcc_serial_rx (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Serial pins
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   input wire logic ser_load_in,
   // Word to the core
   pdcc_link_if.rx link
);
   logic [31:0] shreg;
   logic sclk_q;
   logic load_q;
   wire sclk_rise = ser_clk_in & ~sclk_q;
   wire load_rise = ser_load_in & ~load_q;

   ////////////////////////////////////////////////////////////////////////
   // Edge history
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sclk_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         sclk_q <= ser_clk_in;
         load_q <= ser_load_in;
      end
   end

   // First bit ends up in bit 0 after 32 clocks
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shreg <= 32'h0000_0000;
      end else if (sclk_rise) begin
         shreg <= {ser_data_in, shreg[31:1]};
      end
   end

   // Strobe edge copies the word out, independent of the serial clock
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.word <= 32'h0000_0000;
         link.word_stb <= 1'b0;
      end else begin
         link.word_stb <= load_rise;
         if (load_rise) begin
            link.word <= shreg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_shift_in;
      @(posedge clk_in) disable iff (!nrst_in)
      sclk_rise |=> shreg[31] == $past(ser_data_in) && shreg[30:0] == $past(shreg[31:1]);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

   property p_load_word;
      @(posedge clk_in) disable iff (!nrst_in)
      load_rise |=> link.word_stb && link.word == $past(shreg);
   endproperty
   a_load_word: assert property (p_load_word) else $error("strobe did not load word");
endmodule
`default_nettype wire

// file: rtl/pdcc_fb_divider.sv
// Purpose: Dual-modulus prescaler with A and B counters, the feedback divider
// Assumes: presc_edge_in is a one-cycle pulse per oscillator edge
// Notes: Oscillator edges must be far slower than clk_in in this digital model
`timescale 1ns/100ps
`default_nettype none
module pdcc_fb_divider (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Oscillator edge enable
   input wire logic presc_edge_in,
   // Divider settings and output tick
   pdcc_link_if.fbdiv link
);
   logic [6:0] psc_cnt;
   logic [12:0] cyc;
   wire [6:0] low_mod = pdcc_pkg::psc_low_mod(link.psc_sel);
   // Larger modulus for the first A prescaler cycles, smaller for the rest
   wire [6:0] cur_mod = ({7'h00, cyc} < {7'h00, link.a_val}) ? low_mod + 7'h01 : low_mod;
   wire psc_wrap = presc_edge_in && psc_cnt == cur_mod - 7'h01;
   wire cyc_wrap = psc_wrap && cyc >= link.b_val - 13'h0001;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler, then B counter clocked by the prescaler output
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         psc_cnt <= 7'h00;
         cyc <= 13'h0000;
         link.fb_tick <= 1'b0;
      end else begin
         link.fb_tick <= cyc_wrap;
         if (presc_edge_in) begin
            psc_cnt <= psc_wrap ? 7'h00 : psc_cnt + 7'h01;
         end
         if (psc_wrap) begin
            cyc <= cyc_wrap ? 13'h0000 : cyc + 13'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_modulus;
      @(posedge clk_in) disable iff (!nrst_in)
      psc_wrap |-> psc_cnt == ((cyc < {7'h00, link.a_val}) ? low_mod : low_mod - 7'h01);
   endproperty
   a_modulus: assert property (p_modulus) else $error("wrong prescaler modulus");

   property p_b_wrap;
      @(posedge clk_in) disable iff (!nrst_in)
      psc_wrap && cyc == link.b_val - 13'h0001 |=> link.fb_tick && cyc == 13'h0000;
   endproperty
   a_b_wrap: assert property (p_b_wrap) else $error("B counter did not wrap");
endmodule
`default_nettype wire

// file: dv/pdcc_host_model.sv
// Purpose: Host controller model driving the three-wire programming port
// Assumes: Pins change after the falling edge of clk_in
// Notes: Every level is held two clocks so the sampler cannot miss it
`timescale 1ns/100ps
`default_nettype none
module pdcc_host_model (
   // Clock
   input wire logic clk_in,
   // Serial pins
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic ser_load_out
);
   // One word, bit 0 first, then the load strobe
   task automatic send(input logic [31:0] w);
      for (int i = 0; i < 32; i++) begin
         ser_data_out = w[i];
         repeat (2) @(negedge clk_in);
         ser_clk_out = 1'b1;
         repeat (2) @(negedge clk_in);
         ser_clk_out = 1'b0;
      end
      // Released data line flips so a stale bit never looks valid
      ser_data_out = ~w[31];
      ser_load_out = 1'b1;
      repeat (2) @(negedge clk_in);
      ser_load_out = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask
   initial begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b0;
      ser_load_out = 1'b0;
   end
endmodule
`default_nettype wire

// file: dv/pdcc_pll_ctrl_tb.sv
// Purpose: Self-checking bench for the synthesizer control block
// Assumes: Calibration shortened to 300 clocks
// Notes: Oscillator period 4 clocks, reference period follows the model N
`timescale 1ns/100ps
`default_nettype none
module pdcc_pll_ctrl_tb;
   logic clk_in = 1'b0, nrst_in = 1'b0, ref_in = 1'b0, presc_in = 1'b0, obuf = 1'b0;
   logic sck, sdat, sld, pu, pd, poe, bon, lock, tout, toe, busy;
   logic [2:0] icp;
   logic [1:0] abw, odiv;
   logic [12:0] tgt;
   logic [31:0] w;
   int n_errors = 0, n_compared = 0, seed = 96660, per = 100, cnt = 0, k, p, both_n = 0;
   always #12.5 clk_in = ~clk_in;
   // Oscillator and reference stimulus, ratio set by the model's N
   always @(negedge clk_in) begin
      cnt <= cnt + 1;
      presc_in <= cnt[1];
      ref_in <= (cnt % per) < per / 2;
   end
   // Up and down never stand together while the pulse test is off
   always @(negedge clk_in) begin
      if (pu === 1'b1 && pd === 1'b1) both_n <= both_n + 1;
   end
   pdcc_host_model host (.clk_in(clk_in), .ser_clk_out(sck), .ser_data_out(sdat),
      .ser_load_out(sld));
   pdcc_pll_ctrl #(.CAL_CYCLES(300)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
      .ser_clk_in(sck), .ser_data_in(sdat), .ser_load_in(sld), .chip_en_in(1'b1),
      .outbuf_en_in(obuf), .ref_in(ref_in), .presc_in(presc_in), .pump_up_out(pu),
      .pump_dn_out(pd), .pump_oe_out(poe), .pump_current_out(icp),
      .antibacklash_width_out(abw), .out_div_sel_out(odiv), .buffer_on_out(bon),
      .lock_detect_out(lock), .test_out_out(tout), .test_oe_out(toe),
      .cal_busy_out(busy), .vco_target_mhz_out(tgt));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Bounded wait for lock; reference period comes from N = P*B + A
   task automatic lock_run(input int b, input int a);
      per = ((8 << p) * b + a) * 4;
      k = 0;
      while (lock !== 1'b1 && k < 8 * per) begin
         @(negedge clk_in);
         k++;
      end
   endtask
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_in);
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (20) @(negedge clk_in);
      nrst_in = 1'b1;
      @(negedge clk_in);
      chk("pump_oe", 1, poe);
      chk("abw", 0, abw);
      chk("buffer", 1, bon);
      $display("reset test done");
      // Setup: pin-controlled buffer, divide by four, random pump current
      obuf = $random(seed);
      w = 32'h1000_1600 | (($random(seed) & 7) << 5);
      host.send(w);
      chk("odiv", 2, odiv);
      chk("icp", w[7:5], icp);
      chk("buffer_pin", obuf, bon);
      w = 32'h8000_0001 | (($random(seed) & 32'h1fff) << 18);
      host.send(w);
      chk("target", w[30:18], tgt);
      host.send(32'h0600_0002);
      chk("busy", 1, busy);
      chk("refused", 0, toe);
      k = 0;
      while (busy === 1'b1 && k < 400) begin
         @(negedge clk_in);
         k++;
      end
      chk("cal_len", 1, k > 150 && k < 170);
      $display("calibration test done");
      // First counter word loads without lock-load; test pin shows lock
      p = $random(seed) & 3;
      host.send(32'h0200_3042 | (p << 4));
      lock_run(3, 1);
      chk("lock", 1, lock);
      // Test pin is one flop behind the lock level
      @(negedge clk_in);
      chk("test_lock", 1, tout);
      // Without lock-load the working dividers must not move
      host.send(32'h0200_4002 | (p << 4));
      repeat (2 * per) @(negedge clk_in);
      chk("held", 1, lock);
      host.send(32'h2200_4002 | (p << 4));
      chk("relock_drop", 0, lock);
      lock_run(4, 0);
      chk("relock", 1, lock);
      // Later calibration words leave the start bit low: no new run
      w = 32'h0000_0001 | (($random(seed) & 32'h1fff) << 18);
      host.send(w);
      chk("no_cal", 0, busy);
      chk("target2", w[30:18], tgt);
      chk("still_lock", 1, lock);
      $display("divider test done");
      // Fixed test pin levels and high impedance
      for (int i = 0; i < 3; i++) begin
         host.send(({4'h3, 4'h7, 4'h0} >> (8 - 4 * i) & 32'hf) << 25 | 32'h2);
         chk("test_oe", i < 2, toe);
         if (i < 2) chk("test_out", i == 0, tout);
      end
      $display("test pin test done");
      // Soft reset then setup again with reset bit low
      host.send(32'h1000_1610);
      chk("odiv_rst", 0, odiv);
      chk("lock_rst", 0, lock);
      host.send(32'h3000_1000);
      chk("pump_hz", 0, poe);
      // Calibration data gone, so the read back pin asks for a new run
      host.send(32'h0c00_3002);
      chk("readback", 1, tout);
      host.send(32'h1000_1000);
      chk("pump_oe2", 1, poe);
      chk("pump_both", 0, both_n);
      $display("soft reset test done");
      print_verdict();
   end
endmodule
`default_nettype wire
